// >>> rtl/dsls_regs.svh
/*
 Register indices, field positions, command codes and reset values of the drive security lock block.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef DSLS_REGS_SVH
`define DSLS_REGS_SVH

// Word indices; the byte address is four times the index.
`define DSLS_IDX_CMD 4'h0
`define DSLS_IDX_CTRL 4'h1
`define DSLS_IDX_SECCNT 4'h2
`define DSLS_IDX_STATUS 4'h3
`define DSLS_IDX_CONFIG 4'h4
`define DSLS_IDX_PWD_MSB 1'h1

`define DSLS_CMD_SET_PWD 8'hF1
`define DSLS_CMD_UNLOCK 8'hF2
`define DSLS_CMD_ERASE_PREP 8'hF3
`define DSLS_CMD_ERASE_UNIT 8'hF4
`define DSLS_CMD_FREEZE 8'hF5
`define DSLS_CMD_DISABLE_PWD 8'hF6

`define DSLS_CTRL_ID_BIT 0
`define DSLS_CTRL_LEVEL_BIT 8

`define DSLS_ST_ABORT 0
`define DSLS_ST_FROZEN 1
`define DSLS_ST_LOCKED 2
`define DSLS_ST_ENABLED 3
`define DSLS_ST_LEVEL_MAX 4
`define DSLS_ST_EXPIRED 5
`define DSLS_ST_PREP 6
`define DSLS_ST_CNT_LSB 8

`define DSLS_CFG_SUPPORT_BIT 0
`define DSLS_CFG_RESET 32'h0000_0001
`define DSLS_RETRY_INIT 5

`endif

// >>> rtl/dsls_pkg.sv
/*
 Types shared by the drive security lock block: bus carriers and bus states.
 Assumes an Avalon-MM master with 32-bit data and byte addresses.
*/
package dsls_pkg;

   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
   } dsls_avm_req_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } dsls_avm_rsp_t;

   typedef enum logic [0:0] {
      DSLS_BUS_IDLE = 1'b0,
      DSLS_BUS_ACK = 1'b1
   } dsls_bus_t;

endpackage

// >>> rtl/dsls_core.sv
/*
 Security lock state of a drive command interpreter: freeze, set password, unlock, disable and erase.
 Assumes an Avalon-MM master on the same clock and a hardware reset pin from another domain.
*/
`timescale 1ns/1ns
`include "dsls_regs.svh"

module dsls_core #(
   parameter int RETRY_LIMIT = `DSLS_RETRY_INIT
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire dsls_pkg::dsls_avm_req_t avm_req,
   output dsls_pkg::dsls_avm_rsp_t avm_rsp,
   input wire logic hw_reset_pin,
   output logic wear_level_pulse,
   output logic erase_pulse
);
   import dsls_pkg::*;

   // A three-bit counter cannot hold more than seven tries, and zero tries would lock out every unlock.
   if (RETRY_LIMIT < 1 || RETRY_LIMIT > 7)
   begin : g_bad_retry
      $error("RETRY_LIMIT must lie between 1 and 7");
   end

   localparam logic [2:0] RETRY_INIT = 3'(RETRY_LIMIT);

   dsls_bus_t bus_q;
   logic [31:0] rdata_q;
   logic [31:0] ctrl_q;
   logic [7:0] seccnt_q;
   logic [31:0] config_q;
   logic [7:0][31:0] pwd_q;
   logic [7:0][31:0] user_q;
   logic [7:0][31:0] master_q;
   logic frozen_q, locked_q, enabled_q, level_q, prep_q, abort_q;
   logic [2:0] cnt_q;
   logic [2:0] sync_q;
   logic hlvl_q;
   logic wear_q, erase_q;

   // Bus: every access waits one cycle, so the answer is taken at the second edge.
   wire acc = (avm_req.read | avm_req.write) & (bus_q == DSLS_BUS_ACK);
   wire wr = acc & avm_req.write;
   wire rd_first = avm_req.read & (bus_q == DSLS_BUS_IDLE);
   wire [3:0] idx = avm_req.address[5:2];
   wire [2:0] pidx = idx[2:0];
   wire is_pwd = idx[3] == `DSLS_IDX_PWD_MSB;
   wire [7:0] cmd = avm_req.writedata[7:0];
   wire cmd_go = wr & (idx == `DSLS_IDX_CMD);

   // Read data is latched in the wait cycle, so it comes from a flip-flop at the cost of one fixed wait state.
   wire wait_w = (avm_req.read | avm_req.write) & (bus_q == DSLS_BUS_IDLE);
   assign avm_rsp = '{waitrequest: wait_w, readdata: rdata_q};

   // Hardware reset pin: a change counts once the second and third stages agree.
   wire hlvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : hlvl_q;
   wire hrst_ev = hlvl_d & ~hlvl_q;

   // Command decode.
   wire supported = config_q[`DSLS_CFG_SUPPORT_BIT];
   wire id_master = ctrl_q[`DSLS_CTRL_ID_BIT];
   wire lvl_in = ctrl_q[`DSLS_CTRL_LEVEL_BIT];
   wire match_user = pwd_q == user_q;
   wire match_master = pwd_q == master_q;
   wire sel_match = id_master ? match_master : match_user;
   wire expired = cnt_q == 3'h0;
   wire c_frz = cmd == `DSLS_CMD_FREEZE;
   wire c_set = cmd == `DSLS_CMD_SET_PWD;
   wire c_unl = cmd == `DSLS_CMD_UNLOCK;
   wire c_dis = cmd == `DSLS_CMD_DISABLE_PWD;
   wire c_prep = cmd == `DSLS_CMD_ERASE_PREP;
   wire c_ers = cmd == `DSLS_CMD_ERASE_UNIT;
   wire freeze_go = cmd_go & c_frz & supported;
   wire wear_go = cmd_go & c_frz & ~supported;
   wire set_ok = cmd_go & c_set & ~frozen_q;
   wire unl_refuse = frozen_q | expired | (id_master & level_q);
   wire unl_ok = cmd_go & c_unl & ~unl_refuse & sel_match;
   wire unl_miss = cmd_go & c_unl & ~unl_refuse & ~sel_match;
   wire dis_ok = cmd_go & c_dis & ~frozen_q & sel_match;
   wire ers_ok = cmd_go & c_ers & ~frozen_q & ~expired & prep_q & sel_match;
   wire rejected = (c_set & ~set_ok) | (c_unl & ~unl_ok) | (c_dis & ~dis_ok) | (c_ers & ~ers_ok);
   wire abort_now = cmd_go & rejected;

   logic [31:0] status_w;
   logic [31:0] rmux;

   always_comb
   begin
      status_w = 32'h0;
      status_w[`DSLS_ST_ABORT] = abort_q;
      status_w[`DSLS_ST_FROZEN] = frozen_q;
      status_w[`DSLS_ST_LOCKED] = locked_q;
      status_w[`DSLS_ST_ENABLED] = enabled_q;
      status_w[`DSLS_ST_LEVEL_MAX] = level_q;
      status_w[`DSLS_ST_EXPIRED] = expired;
      status_w[`DSLS_ST_PREP] = prep_q;
      status_w[`DSLS_ST_CNT_LSB +: 3] = cnt_q;
   end

   always_comb
   begin
      if (is_pwd)
         rmux = pwd_q[pidx];
      else
      begin
         case (idx)
            `DSLS_IDX_CTRL: rmux = ctrl_q;
            `DSLS_IDX_SECCNT: rmux = {24'h0, seccnt_q};
            `DSLS_IDX_STATUS: rmux = status_w;
            `DSLS_IDX_CONFIG: rmux = config_q;
            default: rmux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bus_q <= DSLS_BUS_IDLE;
         rdata_q <= 32'h0;
      end
      else
      begin
         bus_q <= avm_rsp.waitrequest ? DSLS_BUS_ACK : DSLS_BUS_IDLE;
         if (rd_first)
            rdata_q <= rmux;
      end
   end

   // Sector buffer and plain settings written by software.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pwd_q <= '0;
         ctrl_q <= 32'h0;
         config_q <= `DSLS_CFG_RESET;
      end
      else if (wr)
      begin
         if (is_pwd)
            pwd_q[pidx] <= avm_req.writedata;
         else if (idx == `DSLS_IDX_CTRL)
            ctrl_q <= avm_req.writedata;
         else if (idx == `DSLS_IDX_CONFIG)
            config_q <= avm_req.writedata;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         seccnt_q <= 8'h0;
      else if (freeze_go)
         seccnt_q <= 8'h0;
      else if (wr & (idx == `DSLS_IDX_SECCNT))
         seccnt_q <= avm_req.writedata[7:0];
   end

   // Stored passwords live only in flip-flops, so power-on loses them; the pin reset keeps them.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         user_q <= '0;
         master_q <= '0;
         level_q <= 1'b0;
         enabled_q <= 1'b0;
      end
      else if (set_ok & ~id_master)
      begin
         user_q <= pwd_q;
         level_q <= lvl_in;
         enabled_q <= 1'b1;
      end
      else if (set_ok)
         master_q <= pwd_q;
      else if (dis_ok | ers_ok)
      begin
         enabled_q <= 1'b0;
         if (ers_ok)
            user_q <= '0;
      end
   end

   // A pin reset outranks a same-cycle command in these flags; passwords, enable, level, sector count and pulses still take it.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frozen_q <= 1'b0;
         locked_q <= 1'b0;
         cnt_q <= RETRY_INIT;
         prep_q <= 1'b0;
         abort_q <= 1'b0;
      end
      else if (hrst_ev)
      begin
         frozen_q <= 1'b0;
         locked_q <= enabled_q;
         cnt_q <= RETRY_INIT;
         prep_q <= 1'b0;
         abort_q <= 1'b0;
      end
      else if (cmd_go)
      begin
         frozen_q <= frozen_q | freeze_go;
         if (unl_ok | dis_ok | ers_ok)
            locked_q <= 1'b0;
         if (unl_miss & locked_q)
            cnt_q <= cnt_q - 3'h1;
         prep_q <= c_prep;
         abort_q <= abort_now;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync_q <= 3'h0;
         hlvl_q <= 1'b0;
         wear_q <= 1'b0;
         erase_q <= 1'b0;
      end
      else
      begin
         sync_q <= {sync_q[1:0], hw_reset_pin};
         hlvl_q <= hlvl_d;
         wear_q <= wear_go;
         erase_q <= ers_ok;
      end
   end

   assign wear_level_pulse = wear_q;
   assign erase_pulse = erase_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   wire no_hr = ~hrst_ev;

   AST_FREEZE: assert property (freeze_go && no_hr |=> frozen_q && seccnt_q == 8'h0)
      else $error("Freeze did not set frozen and clear sector count.");
   AST_FROZEN_HOLD: assert property (frozen_q && no_hr |=> frozen_q)
      else $error("Frozen state left without a hardware reset.");
   AST_REFREEZE: assert property (freeze_go && frozen_q && no_hr |=> frozen_q && !abort_q)
      else $error("Freeze while frozen failed.");
   AST_FROZEN_REJECT: assert property (cmd_go && frozen_q && no_hr && (c_set || c_unl || c_dis || c_ers)
      |=> abort_q && $stable(locked_q) && $stable(enabled_q))
      else $error("Frozen drive accepted a lock command.");
   AST_WEAR: assert property (wear_go && no_hr |=> wear_level_pulse && $stable(frozen_q) ##1 !wear_level_pulse)
      else $error("Unsupported freeze did not become one wear-level pulse.");
   AST_SET_USER: assert property (set_ok && !id_master |=> enabled_q && user_q == $past(pwd_q)
      && level_q == $past(lvl_in))
      else $error("User password not stored.");
   AST_SET_MASTER: assert property (set_ok && id_master |=> master_q == $past(pwd_q)
      && $stable(level_q) && $stable(enabled_q))
      else $error("Master set changed level or lock.");
   AST_MAX_MASTER: assert property (cmd_go && c_unl && id_master && level_q && no_hr |=> abort_q)
      else $error("Master unlock accepted at maximum level.");
   AST_MISS_DEC: assert property (unl_miss && locked_q && no_hr |=> abort_q && locked_q
      && cnt_q == 3'($past(cnt_q) - 3'h1))
      else $error("Mismatch did not abort and decrement.");
   AST_EXPIRED: assert property (cmd_go && expired && (c_unl || c_ers) && no_hr |=> abort_q && cnt_q == 3'h0)
      else $error("Expired counter let a command through.");
   AST_UNLOCKED_CNT: assert property (cmd_go && c_unl && !locked_q && no_hr |=> $stable(cnt_q))
      else $error("Unlock while unlocked changed the counter.");
   AST_PIN_RESET: assert property (hrst_ev |=> cnt_q == RETRY_INIT && !frozen_q && !prep_q)
      else $error("Pin reset did not restore counter and frozen state.");
   AST_PREP: assert property (cmd_go && c_ers && !prep_q && no_hr |=> abort_q && !erase_pulse)
      else $error("Erase ran without prepare.");
   AST_BUS: assert property (avm_rsp.waitrequest ##1 $stable(avm_req) |-> !avm_rsp.waitrequest)
      else $error("Held request not answered at the second edge.");
   AST_DISABLE_OK: assert property (dis_ok && no_hr |=> !locked_q && !enabled_q
      && $stable(master_q))
      else $error("Disable did not leave the lock or lost the master password.");
   AST_DISABLE_MISS: assert property (cmd_go && c_dis && !frozen_q && !sel_match && no_hr
      |=> abort_q && $stable(enabled_q) && $stable(locked_q))
      else $error("Disable with a wrong password was accepted.");
   AST_UNLOCK_OK: assert property (unl_ok && no_hr |=> !locked_q && !abort_q && $stable(cnt_q))
      else $error("Matching unlock did not unlock.");
   AST_MAX_USER: assert property (cmd_go && c_unl && !id_master && level_q && match_user && !frozen_q
      && !expired && no_hr |=> !locked_q && !abort_q)
      else $error("User password refused at maximum level.");
   AST_ERASE: assert property (ers_ok && no_hr |=> erase_pulse && !locked_q && !enabled_q
      && !prep_q)
      else $error("Accepted erase did not clear the lock.");
   AST_PREP_ARM: assert property (cmd_go && c_prep && no_hr |=> prep_q && !abort_q)
      else $error("Erase prepare did not arm.");
   AST_REJECT_KEEP: assert property (abort_now && no_hr |=> abort_q && $stable(user_q) && $stable(master_q)
      && $stable(level_q) && $stable(locked_q) && $stable(enabled_q))
      else $error("Rejected command changed the security state.");
   AST_PULSE_ONE: assert property (erase_pulse |=> !erase_pulse)
      else $error("Erase pulse lasted more than one cycle.");
   AST_RDATA: assert property (rd_first && idx == `DSLS_IDX_STATUS && no_hr |=> avm_rsp.readdata[`DSLS_ST_FROZEN]
      == frozen_q && avm_rsp.readdata[`DSLS_ST_CNT_LSB +: 3] == cnt_q)
      else $error("Status read data does not match the state.");
   AST_LOCK_ARM: assert property (hrst_ev |=> locked_q == $past(enabled_q))
      else $error("Pin reset did not arm the lock from the enable flag.");
   // The counter moves only on a locked mismatch or a pin reset, so it can never wrap below zero.
   AST_CNT_HOLD: assert property (!(unl_miss && locked_q) && no_hr |=> $stable(cnt_q))
      else $error("Attempt counter moved without a locked mismatch.");
   AST_NO_UNDERFLOW: assert property (expired && no_hr |=> expired)
      else $error("Expired counter left zero without a reset.");
   AST_SECCNT_WR: assert property (wr && idx == `DSLS_IDX_SECCNT |=> seccnt_q == $past(avm_req.writedata[7:0]))
      else $error("Sector count write did not land.");

   COV_FREEZE: cover property (freeze_go ##[1:100] (cmd_go && c_set));
   COV_UNLOCK: cover property (unl_miss ##[1:50] unl_ok);
   COV_EXPIRE: cover property (unl_miss && cnt_q == 3'h1);
   COV_ERASE: cover property (ers_ok);
   COV_DISABLE: cover property (dis_ok);

endmodule // dsls_core

// >>> testbench/dsls_host.sv
/*
 Host controller model: Avalon-MM master tasks and the password sector transfer.
 Assumes the block answers on the same clock and that the bench calls these tasks one at a time.
*/
`timescale 1ns/1ns
module dsls_host (
   input wire logic clock,
   output dsls_pkg::dsls_avm_req_t req,
   input wire dsls_pkg::dsls_avm_rsp_t rsp
);
   import dsls_pkg::*;
   initial req = '0;
   // The request is held until waitrequest is seen low at a rising edge; no latency is assumed.
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      req <= '{read: !wr, write: wr, address: a, writedata: wd};
      do @(posedge clock); while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      req <= '0;
   endtask
   task automatic sector(input logic [15:0] ctrl, input logic [31:0] pw, input logic [7:0] code);
      logic [31:0] d;
      xfer(1'b1, 6'h04, {16'h0, ctrl}, d);
      for (int i = 0; i < 8; i++)
      begin
         xfer(1'b1, 6'(32 + 4 * i), 32'(pw + i), d);
      end
      xfer(1'b1, 6'h00, {24'h0, code}, d);
   endtask
endmodule // dsls_host

// >>> testbench/tb.sv
/*
 Self-checking bench of the drive security lock block: a row table of commands, then hand-written cases.
 Assumes the host model drives the register bus; a row code of FF stands for a hardware reset pulse.
*/
`timescale 1ns/1ns
module tb;
   import dsls_pkg::*;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] pwd;
      logic [7:0] cmd;
      logic [15:0] exp;
   } dsls_row_t;
   localparam logic [31:0] PA = 32'hA1B2_C3D4;
   localparam logic [31:0] PB = 32'h0B0B_1000;
   localparam logic [31:0] PC = 32'h5E5E_0000;
   localparam logic [31:0] PD = 32'hD00D_7700;
   localparam dsls_row_t ROWS [18] = '{
      '{16'h0, PA, 8'hF1, 16'h508}, '{16'h0, PA, 8'hFF, 16'h50C}, '{16'h1, PB, 8'hF1, 16'h50C},
      '{16'h0, PC, 8'hF2, 16'h40D}, '{16'h1, PB, 8'hF2, 16'h408}, '{16'h0, PC, 8'hF2, 16'h409},
      '{16'h0, PA, 8'hF4, 16'h409}, '{16'h0, PA, 8'hF3, 16'h448}, '{16'h0, PA, 8'hF4, 16'h400},
      '{16'h100, PD, 8'hF1, 16'h418}, '{16'h0, PA, 8'hFF, 16'h51C}, '{16'h1, PB, 8'hF2, 16'h51D},
      '{16'h0, PD, 8'hF2, 16'h518}, '{16'h0, PA, 8'hF5, 16'h51A}, '{16'h0, PA, 8'hF5, 16'h51A},
      '{16'h0, PD, 8'hF1, 16'h51B}, '{16'h0, PD, 8'hF2, 16'h51B}, '{16'h0, PA, 8'hFF, 16'h51C}};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic hw_reset_pin = 1'b0;
   dsls_avm_req_t avm_req;
   dsls_avm_rsp_t avm_rsp;
   logic wear_level_pulse;
   logic erase_pulse;
   logic [31:0] d;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_wear = 0;
   int n_erase = 0;
   always #25 clock = ~clock;
   dsls_core dut (.clock(clock), .reset_n(reset_n), .avm_req(avm_req), .avm_rsp(avm_rsp),
      .hw_reset_pin(hw_reset_pin), .wear_level_pulse(wear_level_pulse), .erase_pulse(erase_pulse));
   dsls_host host (.clock(clock), .req(avm_req), .rsp(avm_rsp));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // The ceiling is about four times the expected run, so a stuck handshake ends the run.
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (wear_level_pulse === 1'b1) n_wear = n_wear + 1;
      if (erase_pulse === 1'b1) n_erase = n_erase + 1;
      if (cyc == 4000)
      begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic st(input logic [31:0] exp);
      host.xfer(1'b0, 6'h0C, 32'h0, d);
      chk(d, exp);
   endtask
   task automatic hwrst;
      hw_reset_pin <= 1'b1;
      repeat (5) @(posedge clock);
      hw_reset_pin <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   initial
   begin
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      st(32'h500);
      $display("reset test done");
      for (int i = 0; i < 18; i++)
      begin
         if (ROWS[i].cmd == 8'hFF)
            hwrst();
         else
            host.sector(ROWS[i].ctrl, ROWS[i].pwd, ROWS[i].cmd);
         st({16'h0, ROWS[i].exp});
         $display("row %0d done", i);
      end
      chk(32'(n_erase), 32'h1);
      for (int k = 4; k >= 0; k--)
      begin
         host.sector(16'h0, PC, 8'hF2);
         st((32'(k) << 8) | 32'h1D | ((k == 0) ? 32'h20 : 32'h0));
      end
      host.sector(16'h0, PD, 8'hF2);
      st(32'h3D);
      host.sector(16'h0, PD, 8'hF3);
      host.sector(16'h0, PD, 8'hF4);
      st(32'h3D);
      chk(32'(n_erase), 32'h1);
      $display("expiry test done");
      host.xfer(1'b1, 6'h08, 32'h5A, d);
      host.xfer(1'b1, 6'h00, 32'hF5, d);
      host.xfer(1'b0, 6'h08, 32'h0, d);
      chk(d, 32'h0);
      st(32'h3E);
      hwrst();
      st(32'h51C);
      $display("sector count test done");
      host.xfer(1'b1, 6'h10, 32'h0, d);
      host.xfer(1'b1, 6'h00, 32'hF5, d);
      st(32'h51C);
      chk(32'(n_wear), 32'h1);
      host.xfer(1'b0, 6'h14, 32'h0, d);
      chk(d, 32'h0);
      $display("wear level test done");
      host.sector(16'h0, PA, 8'hF6);
      st(32'h51D);
      host.sector(16'h0, PD, 8'hF6);
      st(32'h510);
      host.sector(16'h0, PA, 8'hF1);
      st(32'h508);
      host.sector(16'h1, PB, 8'hF2);
      st(32'h508);
      $display("disable test done");
      end_sim();
   end
endmodule // tb
